// >>> core/sirb0_bank.sv
/*
  bank 0 register front end: data port steering, mode-dependent interrupt
  enable register, legacy priority encoding and the interrupt request.
  assumes the host port, events and register contents of the other bank 0
  registers come from logic on core_clk; no pin enters here unsynchronised.
*/
////////////////////////////////////////////////////////////////////////////////
// Contract
// - after reset run legacy mode without fifos, classic single-buffer behaviour
// - bank 0 decodes eight byte offsets, data at 0 through scratch at 7
// - data read returns holding register, or receive fifo bottom when enabled
// - data write loads holding register, or pushes transmit fifo when enabled
// - dma cycles always hit the data ports whatever bank is selected
// - enable bits 4, 5 and 7 settable only in extended mode, else held clear
// - enable bits are interpreted by one of five mode groups
// - enable register resets to legacy layout with every bit cleared
// - legacy bit 0 gates receive level and timeout events, codes 0100 and 1100
// - legacy bit 1 gates transmitter low level event, code 0010
// - legacy bit 2 gates link status events, code 0110
// - legacy bit 3 gates modem status events, code 0000
// - extended bit 0 gates receive at threshold or receive timeout
// - extended bit 1 gates transmit below threshold or holding register empty
// - extended bit 4 gates dma terminal count only while dma is enabled
// - extended bit 5 gates transmitter and transmit fifo both empty
// - extended bit 6 reserved, bit 7 enables the timer interrupt
// - extended sir bit 5 gates transmitter empty and pipeline load
// - extended mode active only while extended select is one
// - legacy priority: link, receive or timeout, transmitter low, modem
module sirb0_bank
  import sirb0_pkg::*;
#(
  parameter int DATA_W = 8
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire sirb0_req_t host_req,
  input wire sirb0_ev_t events,
  input wire logic extended_select,
  input wire logic [2:0] mode_sel,
  input wire logic fifo_enable,
  input wire logic dma_enable,
  input wire logic bank0_sel,
  input wire logic [7:0] rx_hold_data,
  input wire logic [7:0] rx_fifo_bottom,
  input wire logic [7:0] event_identification_reg,
  input wire logic [7:0] line_control_reg,
  input wire logic [7:0] modem_control_reg,
  input wire logic [7:0] line_status_reg,
  input wire logic [7:0] modem_status_reg,
  input wire logic [7:0] scratch_reg,
  output logic [7:0] rdata,
  output logic tx_hold_load,
  output logic tx_fifo_push,
  output logic [7:0] tx_byte,
  output logic rx_hold_pop,
  output logic rx_fifo_pop,
  output logic [7:0] interrupt_enable_reg,
  output logic [3:0] legacy_event_code,
  output logic irq
);

  // the ports are byte-wide, so any other width is refused at elaboration
  if (DATA_W != 8) begin : g_width_check
    $error("sirb0_bank serves byte-wide data only");
  end

  function automatic logic is_data(input sirb0_req_t r, input logic bsel, input logic rd);
    logic cpu;
    cpu = bsel && (r.addr == SIRB0_OFF_DATA) && (rd ? r.rd : r.wr);
    return cpu || (rd ? r.dma_rd : r.dma_wr);
  endfunction

  sirb0_grp_t grp;
  logic ext;
  logic [7:0] ien_d, ien_q, rdata_d, rdata_q, txb_d, txb_q;
  logic [3:0] code_d, code_q;
  logic thl_d, thl_q, tfp_d, tfp_q, rhp_d, rhp_q, rfp_d, rfp_q, irq_d, irq_q;
  logic data_rd, data_wr;

  ////////////////////////////////////////////////////////////////////////////
  // mode group
  always_comb begin
    ext = extended_select;
    grp = SIRB0_GRP_LEGACY;
    if (ext) begin
      case (mode_sel)
        3'h1: grp = SIRB0_GRP_EXT_SIR;
        3'h2: grp = SIRB0_GRP_FAST_IR;
        3'h3: grp = SIRB0_GRP_CONSUMER;
        default: grp = SIRB0_GRP_EXT_UART;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register port
  always_comb begin
    data_rd = is_data(host_req, bank0_sel, 1'b1);
    data_wr = is_data(host_req, bank0_sel, 1'b0);
    ien_d = ien_q;
    if (bank0_sel && host_req.wr && host_req.addr == SIRB0_OFF_IEN) begin
      ien_d = host_req.wdata & (ext ? SIRB0_IEN_EXT_MASK : SIRB0_IEN_LEGACY_MASK);
    end
    // falling back out of extended mode drops the upper enables at once
    if (!ext) begin
      ien_d = ien_d & SIRB0_IEN_LEGACY_MASK;
    end
    thl_d = data_wr && !fifo_enable;
    tfp_d = data_wr && fifo_enable;
    txb_d = data_wr ? host_req.wdata : txb_q;
    rhp_d = data_rd && !fifo_enable;
    rfp_d = data_rd && fifo_enable;
    rdata_d = rdata_q;
    if (data_rd) begin
      rdata_d = fifo_enable ? rx_fifo_bottom : rx_hold_data;
    end else if (bank0_sel && host_req.rd) begin
      case (host_req.addr)
        SIRB0_OFF_IEN: rdata_d = ien_q;
        SIRB0_OFF_EID: rdata_d = event_identification_reg;
        SIRB0_OFF_LCR: rdata_d = line_control_reg;
        SIRB0_OFF_MCR: rdata_d = modem_control_reg;
        SIRB0_OFF_LSR: rdata_d = line_status_reg;
        SIRB0_OFF_MSR: rdata_d = modem_status_reg;
        SIRB0_OFF_SCR: rdata_d = scratch_reg;
        default: rdata_d = rdata_q;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt request and legacy code
  always_comb begin
    code_d = SIRB0_EV_NONE;
    irq_d = 1'b0;
    if (grp == SIRB0_GRP_LEGACY) begin
      // first match wins, so the order below is the priority
      if (ien_q[SIRB0_BIT_LS] && events.line_event) begin
        code_d = SIRB0_EV_LS;
      end else if (ien_q[SIRB0_BIT_RX] && events.rx_timeout) begin
        code_d = SIRB0_EV_RXTO;
      end else if (ien_q[SIRB0_BIT_RX] && events.rx_high) begin
        code_d = SIRB0_EV_RX;
      end else if (ien_q[SIRB0_BIT_TX] && events.tx_low) begin
        code_d = SIRB0_EV_TX;
      end else if (ien_q[SIRB0_BIT_MS] && events.modem_event) begin
        code_d = SIRB0_EV_MS;
      end
      irq_d = (code_d != SIRB0_EV_NONE);
    end else begin
      irq_d = (ien_q[SIRB0_BIT_RX] && (events.rx_high || events.rx_timeout))
        || (ien_q[SIRB0_BIT_TX] && events.tx_low)
        || (ien_q[SIRB0_BIT_LS] && events.line_event)
        || (ien_q[SIRB0_BIT_MS] && events.modem_event)
        || (ien_q[SIRB0_BIT_DMA] && dma_enable && events.dma_tc)
        || (ien_q[SIRB0_BIT_TMR] && events.timer)
        || (ien_q[SIRB0_BIT_TXEMP] && events.tx_empty)
        || (grp == SIRB0_GRP_EXT_SIR && ien_q[SIRB0_BIT_TXEMP] && events.pipe_load);
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      ien_q <= SIRB0_IEN_RESET;
      rdata_q <= SIRB0_BYTE_RESET;
      txb_q <= SIRB0_BYTE_RESET;
      code_q <= SIRB0_EV_NONE;
      thl_q <= 1'b0;
      tfp_q <= 1'b0;
      rhp_q <= 1'b0;
      rfp_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      ien_q <= ien_d;
      rdata_q <= rdata_d;
      txb_q <= txb_d;
      code_q <= code_d;
      thl_q <= thl_d;
      tfp_q <= tfp_d;
      rhp_q <= rhp_d;
      rfp_q <= rfp_d;
      irq_q <= irq_d;
    end
  end

  assign interrupt_enable_reg = ien_q;
  assign rdata = rdata_q;
  assign tx_byte = txb_q;
  assign tx_hold_load = thl_q;
  assign tx_fifo_push = tfp_q;
  assign rx_hold_pop = rhp_q;
  assign rx_fifo_pop = rfp_q;
  assign legacy_event_code = code_q;
  assign irq = irq_q;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  sequence s_dma_write;
    host_req.dma_wr && !fifo_enable;
  endsequence

  sequence s_cpu_data_write;
    bank0_sel && host_req.wr && host_req.addr == SIRB0_OFF_DATA && !host_req.dma_wr;
  endsequence

  sequence s_cpu_data_read;
    bank0_sel && host_req.rd && host_req.addr == SIRB0_OFF_DATA;
  endsequence

  sequence s_ien_write;
    bank0_sel && host_req.wr && host_req.addr == SIRB0_OFF_IEN;
  endsequence

  a_upper_bits_clear: assert property (@(posedge core_clk) disable iff (sys_rst)
    !ext |=> (ien_q[7:4] == 4'h0))
    else $error("upper enables set outside extended mode");
  a_bit6_reserved: assert property (@(posedge core_clk) disable iff (sys_rst)
    !ien_q[SIRB0_BIT_RSV6])
    else $error("reserved enable bit 6 set");
  a_dma_hits_data: assert property (@(posedge core_clk) disable iff (sys_rst)
    s_dma_write |=> tx_hold_load && tx_byte == $past(host_req.wdata))
    else $error("dma write missed the holding register");
  a_fifo_read_pop: assert property (@(posedge core_clk) disable iff (sys_rst)
    (bank0_sel && host_req.rd && host_req.addr == SIRB0_OFF_DATA && fifo_enable)
    |=> rx_fifo_pop && !rx_hold_pop && rdata == $past(rx_fifo_bottom))
    else $error("fifo read not steered");
  a_fifo_write_push: assert property (@(posedge core_clk) disable iff (sys_rst)
    (bank0_sel && host_req.wr && host_req.addr == SIRB0_OFF_DATA && fifo_enable
     && !host_req.dma_wr) |=> tx_fifo_push && !tx_hold_load)
    else $error("fifo write not steered");
  a_link_first: assert property (@(posedge core_clk) disable iff (sys_rst)
    (grp == SIRB0_GRP_LEGACY && ien_q[SIRB0_BIT_LS] && events.line_event)
    |=> legacy_event_code == SIRB0_EV_LS && irq)
    else $error("link status not top priority");
  a_dma_gated: assert property (@(posedge core_clk) disable iff (sys_rst)
    (ext && !dma_enable && ien_q == 8'h10) |=> !irq)
    else $error("terminal count irq while dma disabled");
  a_irq_idle: assert property (@(posedge core_clk) disable iff (sys_rst)
    (ien_q == 8'h00) |=> !irq)
    else $error("irq without any enable");
  a_reset_clear: assert property (@(posedge core_clk)
    sys_rst |=> ien_q == SIRB0_IEN_RESET && !irq)
    else $error("enable register not cleared by reset");
  a_reset_outputs: assert property (@(posedge core_clk)
    sys_rst |=> legacy_event_code == SIRB0_EV_NONE && !tx_hold_load && !tx_fifo_push
      && !rx_hold_pop && !rx_fifo_pop)
    else $error("outputs not quiet after reset");
  a_hold_write_load: assert property (@(posedge core_clk) disable iff (sys_rst)
    s_cpu_data_write ##0 !fifo_enable
    |=> tx_hold_load && !tx_fifo_push && tx_byte == $past(host_req.wdata))
    else $error("data write not loaded into holding register");
  a_hold_read_pop: assert property (@(posedge core_clk) disable iff (sys_rst)
    s_cpu_data_read ##0 !fifo_enable
    |=> rx_hold_pop && !rx_fifo_pop && rdata == $past(rx_hold_data))
    else $error("holding register read not steered");
  a_dma_read_port: assert property (@(posedge core_clk) disable iff (sys_rst)
    host_req.dma_rd && fifo_enable |=> rx_fifo_pop && rdata == $past(rx_fifo_bottom))
    else $error("dma read missed the receive port");
  a_bank_refused: assert property (@(posedge core_clk) disable iff (sys_rst)
    !bank0_sel && !host_req.dma_rd && !host_req.dma_wr
    |=> !tx_hold_load && !tx_fifo_push && !rx_hold_pop && !rx_fifo_pop)
    else $error("data port moved while bank 0 deselected");
  a_ien_legacy_write: assert property (@(posedge core_clk) disable iff (sys_rst)
    s_ien_write ##0 !ext |=> ien_q == ($past(host_req.wdata) & SIRB0_IEN_LEGACY_MASK))
    else $error("legacy enable write not masked");
  a_ien_ext_write: assert property (@(posedge core_clk) disable iff (sys_rst)
    s_ien_write ##0 ext |=> ien_q == ($past(host_req.wdata) & SIRB0_IEN_EXT_MASK))
    else $error("extended enable write not masked");
  a_ien_holds: assert property (@(posedge core_clk) disable iff (sys_rst)
    ext && !(bank0_sel && host_req.wr && host_req.addr == SIRB0_OFF_IEN) |=> $stable(ien_q))
    else $error("enable register changed without a write");
  a_rx_timeout_code: assert property (@(posedge core_clk) disable iff (sys_rst)
    grp == SIRB0_GRP_LEGACY && ien_q[SIRB0_BIT_RX] && events.rx_timeout && !events.line_event
    |=> legacy_event_code == SIRB0_EV_RXTO && irq)
    else $error("receive timeout code wrong");
  a_rx_level_code: assert property (@(posedge core_clk) disable iff (sys_rst)
    grp == SIRB0_GRP_LEGACY && ien_q[SIRB0_BIT_RX] && events.rx_high && !events.rx_timeout
      && !events.line_event |=> legacy_event_code == SIRB0_EV_RX && irq)
    else $error("receive level code wrong");
  a_tx_low_code: assert property (@(posedge core_clk) disable iff (sys_rst)
    grp == SIRB0_GRP_LEGACY && ien_q[SIRB0_BIT_TX] && events.tx_low && !events.line_event
      && !events.rx_high && !events.rx_timeout |=> legacy_event_code == SIRB0_EV_TX && irq)
    else $error("transmitter low code wrong");
  a_modem_code_last: assert property (@(posedge core_clk) disable iff (sys_rst)
    grp == SIRB0_GRP_LEGACY && ien_q[SIRB0_BIT_MS] && events.modem_event && !events.line_event
      && !events.rx_high && !events.rx_timeout && !events.tx_low
    |=> legacy_event_code == SIRB0_EV_MS && irq)
    else $error("modem status code wrong");
  a_legacy_quiet: assert property (@(posedge core_clk) disable iff (sys_rst)
    grp == SIRB0_GRP_LEGACY && !events.rx_high && !events.rx_timeout && !events.tx_low
      && !events.line_event && !events.modem_event
    |=> !irq && legacy_event_code == SIRB0_EV_NONE)
    else $error("legacy irq from an extended-only source");
  a_ext_no_code: assert property (@(posedge core_clk) disable iff (sys_rst)
    extended_select |=> legacy_event_code == SIRB0_EV_NONE)
    else $error("legacy code shown in extended mode");
  a_ext_rx_gate: assert property (@(posedge core_clk) disable iff (sys_rst)
    grp != SIRB0_GRP_LEGACY && ien_q[SIRB0_BIT_RX] && (events.rx_high || events.rx_timeout)
    |=> irq)
    else $error("extended receive irq missing");
  a_ext_tx_gate: assert property (@(posedge core_clk) disable iff (sys_rst)
    grp != SIRB0_GRP_LEGACY && ien_q[SIRB0_BIT_TX] && events.tx_low |=> irq)
    else $error("extended transmit irq missing");
  a_tc_enabled: assert property (@(posedge core_clk) disable iff (sys_rst)
    grp != SIRB0_GRP_LEGACY && ien_q[SIRB0_BIT_DMA] && dma_enable && events.dma_tc |=> irq)
    else $error("terminal count irq missing");
  a_tx_empty_gate: assert property (@(posedge core_clk) disable iff (sys_rst)
    grp != SIRB0_GRP_LEGACY && ien_q[SIRB0_BIT_TXEMP] && events.tx_empty |=> irq)
    else $error("transmitter empty irq missing");
  a_timer_gate: assert property (@(posedge core_clk) disable iff (sys_rst)
    grp != SIRB0_GRP_LEGACY && ien_q[SIRB0_BIT_TMR] && events.timer |=> irq)
    else $error("timer irq missing");
  a_pipe_sir_gate: assert property (@(posedge core_clk) disable iff (sys_rst)
    grp == SIRB0_GRP_EXT_SIR && ien_q[SIRB0_BIT_TXEMP] && events.pipe_load |=> irq)
    else $error("pipeline load irq missing");
  a_pipe_uart_quiet: assert property (@(posedge core_clk) disable iff (sys_rst)
    grp == SIRB0_GRP_EXT_UART && ien_q == 8'h20 && !events.tx_empty |=> !irq)
    else $error("pipeline load irq outside sir");

endmodule

// >>> core/sirb0_pkg.sv
/*
  package for the bank 0 register front end of the serial/infrared controller:
  offsets, enable bit positions, event codes, mode groups and carrier structs.
  assumes a byte-wide register port with read and write strobes on core_clk.
*/
package sirb0_pkg;

  localparam logic [2:0] SIRB0_OFF_DATA = 3'h0;
  localparam logic [2:0] SIRB0_OFF_IEN = 3'h1;
  localparam logic [2:0] SIRB0_OFF_EID = 3'h2;
  localparam logic [2:0] SIRB0_OFF_LCR = 3'h3;
  localparam logic [2:0] SIRB0_OFF_MCR = 3'h4;
  localparam logic [2:0] SIRB0_OFF_LSR = 3'h5;
  localparam logic [2:0] SIRB0_OFF_MSR = 3'h6;
  localparam logic [2:0] SIRB0_OFF_SCR = 3'h7;

  localparam int SIRB0_BIT_RX = 0;
  localparam int SIRB0_BIT_TX = 1;
  localparam int SIRB0_BIT_LS = 2;
  localparam int SIRB0_BIT_MS = 3;
  localparam int SIRB0_BIT_DMA = 4;
  localparam int SIRB0_BIT_TXEMP = 5;
  localparam int SIRB0_BIT_RSV6 = 6;
  localparam int SIRB0_BIT_TMR = 7;

  localparam logic [7:0] SIRB0_IEN_RESET = 8'h00;
  localparam logic [7:0] SIRB0_IEN_LEGACY_MASK = 8'h0F;
  localparam logic [7:0] SIRB0_IEN_EXT_MASK = 8'hBF;
  localparam logic [7:0] SIRB0_BYTE_RESET = 8'h00;

  localparam logic [3:0] SIRB0_EV_NONE = 4'h1;
  localparam logic [3:0] SIRB0_EV_LS = 4'h6;
  localparam logic [3:0] SIRB0_EV_RX = 4'h4;
  localparam logic [3:0] SIRB0_EV_RXTO = 4'hC;
  localparam logic [3:0] SIRB0_EV_TX = 4'h2;
  localparam logic [3:0] SIRB0_EV_MS = 4'h0;

  typedef enum logic [2:0] {
    SIRB0_GRP_LEGACY,
    SIRB0_GRP_EXT_UART,
    SIRB0_GRP_EXT_SIR,
    SIRB0_GRP_FAST_IR,
    SIRB0_GRP_CONSUMER
  } sirb0_grp_t;

  // core-side interrupt sources, levels from the neighbouring logic
  typedef struct packed {
    logic rx_high;
    logic rx_timeout;
    logic tx_low;
    logic line_event;
    logic modem_event;
    logic dma_tc;
    logic tx_empty;
    logic pipe_load;
    logic timer;
  } sirb0_ev_t;

  // host-side register access
  typedef struct packed {
    logic rd;
    logic wr;
    logic dma_rd;
    logic dma_wr;
    logic [2:0] addr;
    logic [7:0] wdata;
  } sirb0_req_t;

endpackage

// >>> test/sirb0_host.sv
/*
  host cpu and dma model for the bank 0 front end: one strobe per access.
  assumes the bench calls xfer and reads rdata and pulses one cycle later.
*/
module sirb0_host
  import sirb0_pkg::*;
(
  input wire logic core_clk,
  input wire logic [7:0] rdata,
  input wire logic [3:0] pulses,
  output sirb0_req_t host_req
);
  timeunit 1ns;
  timeprecision 1ps;

  initial host_req = '0;

  // kind: 8 read, 4 write, 2 dma read, 1 dma write
  task automatic xfer(input logic [3:0] kind, input logic [2:0] a, input logic [7:0] d,
      output logic [7:0] q, output logic [3:0] p);
    @(posedge core_clk);
    host_req <= {kind, a, d};
    @(posedge core_clk);
    // released lines turned over so a stale address never looks valid
    host_req <= {4'h0, ~a, ~d};
    #1;
    q = rdata;
    p = pulses;
  endtask
endmodule

// >>> test/tb.sv
/*
  bench for the bank 0 front end: register, data port and interrupt tests.
  assumes the host model drives host_req; the bench drives everything else.
*/
module tb;
  import sirb0_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  logic core_clk, sys_rst, extended_select, fifo_enable, dma_enable, bank0_sel, irq;
  logic [2:0] mode_sel;
  logic [7:0] src [8];
  logic [7:0] rdata, tx_byte, ien, q;
  logic [3:0] code, p;
  wire logic [3:0] pl;
  sirb0_ev_t events;
  sirb0_req_t host_req;
  int errors, samples_checked;
  localparam logic [8:0] LV [10] = '{9'h100, 9'h080, 9'h040, 9'h020, 9'h010, 9'h1F0,
    9'h150, 9'h0D0, 9'h050, 9'h00F};
  localparam logic [3:0] LC [10] = '{4'h4, 4'hC, 4'h2, 4'h6, 4'h0, 4'h6, 4'h4, 4'hC,
    4'h2, 4'h1};
  localparam logic [7:0] XE [12] = '{8'h01, 8'h02, 8'h10, 8'h10, 8'h20, 8'hC0, 8'h40,
    8'h20, 8'h20, 8'h20, 8'h20, 8'h20};
  localparam logic [8:0] XV [12] = '{9'h080, 9'h040, 9'h008, 9'h008, 9'h004, 9'h001,
    9'h001, 9'h002, 9'h002, 9'h004, 9'h004, 9'h004};
  // mode, dma enable, expected request
  localparam logic [4:0] XC [12] = '{5'h01, 5'h01, 5'h00, 5'h03, 5'h01, 5'h01, 5'h00,
    5'h05, 5'h00, 5'h09, 5'h0D, 5'h05};

  sirb0_bank dut_u (.core_clk(core_clk), .sys_rst(sys_rst), .host_req(host_req),
    .events(events), .extended_select(extended_select), .mode_sel(mode_sel),
    .fifo_enable(fifo_enable), .dma_enable(dma_enable), .bank0_sel(bank0_sel),
    .rx_hold_data(src[0]), .rx_fifo_bottom(src[1]), .event_identification_reg(src[2]),
    .line_control_reg(src[3]), .modem_control_reg(src[4]), .line_status_reg(src[5]),
    .modem_status_reg(src[6]), .scratch_reg(src[7]), .rdata(rdata),
    .tx_hold_load(pl[3]), .tx_fifo_push(pl[2]), .tx_byte(tx_byte), .rx_hold_pop(pl[1]),
    .rx_fifo_pop(pl[0]), .interrupt_enable_reg(ien), .legacy_event_code(code), .irq(irq));

  sirb0_host host_u (.core_clk(core_clk), .rdata(rdata), .pulses(pl), .host_req(host_req));

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic acc(input logic [3:0] k, input logic [2:0] a, input logic [7:0] d);
    host_u.xfer(k, a, d, q, p);
  endtask

  // events are levels, so the answer still stands two edges on
  task automatic ev(input logic [8:0] e, input logic [3:0] c, input logic i);
    @(posedge core_clk);
    events <= e;
    repeat (2) @(posedge core_clk);
    #1;
    chk({4'h0, code}, {4'h0, c});
    chk({7'h00, irq}, {7'h00, i});
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  initial begin
    #900000;
    errors++;
    tally_and_finish();
  end

  initial begin
    errors = 0;
    samples_checked = 0;
    sys_rst = 1'b1;
    events = '0;
    extended_select = 1'b0;
    mode_sel = 3'h0;
    fifo_enable = 1'b0;
    dma_enable = 1'b0;
    bank0_sel = 1'b1;
    for (int i = 0; i < 8; i++) src[i] = 8'h10 + 8'(i);
    repeat (10) @(posedge core_clk);
    sys_rst <= 1'b0;
    #1;
    chk(ien, 8'h00);
    chk({4'h0, code}, 8'h01);
    for (int a = 2; a < 8; a++) begin
      acc(4'h8, 3'(a), 8'h00);
      chk(q, 8'h10 + 8'(a));
    end
    $display("test reset and map done");
    acc(4'h4, 3'h0, 8'h5A);
    chk({p, tx_byte[3:0]}, 8'h8A);
    acc(4'h8, 3'h0, 8'h00);
    chk({p, q[3:0]}, 8'h20);
    @(posedge core_clk);
    fifo_enable <= 1'b1;
    acc(4'h4, 3'h0, 8'hA5);
    chk({p, tx_byte[3:0]}, 8'h45);
    acc(4'h8, 3'h0, 8'h00);
    chk({p, q[3:0]}, 8'h11);
    @(posedge core_clk);
    bank0_sel <= 1'b0;
    acc(4'h1, 3'h5, 8'h3C);
    chk({p, tx_byte[3:0]}, 8'h4C);
    acc(4'h2, 3'h5, 8'h00);
    chk({p, q[3:0]}, 8'h11);
    acc(4'h4, 3'h0, 8'h77);
    chk({p, tx_byte[3:0]}, 8'h0C);
    @(posedge core_clk);
    fifo_enable <= 1'b0;
    acc(4'h1, 3'h6, 8'hC3);
    chk({p, tx_byte[3:0]}, 8'h83);
    chk(tx_byte, 8'hC3);
    @(posedge core_clk);
    bank0_sel <= 1'b1;
    $display("test data port done");
    acc(4'h4, 3'h1, 8'hFF);
    acc(4'h8, 3'h1, 8'h00);
    chk(q, 8'h0F);
    for (int i = 0; i < 10; i++) ev(LV[i], LC[i], LC[i] !== 4'h1);
    acc(4'h4, 3'h1, 8'h00);
    ev(9'h1FF, 4'h1, 1'b0);
    $display("test legacy enables done");
    @(posedge core_clk);
    extended_select <= 1'b1;
    acc(4'h4, 3'h1, 8'hFF);
    acc(4'h8, 3'h1, 8'h00);
    chk(q, 8'hBF);
    ev(9'h1F0, 4'h1, 1'b1);
    for (int i = 0; i < 12; i++) begin
      @(posedge core_clk);
      mode_sel <= XC[i][4:2];
      dma_enable <= XC[i][1];
      acc(4'h4, 3'h1, XE[i]);
      ev(XV[i], 4'h1, XC[i][0]);
    end
    $display("test extended enables done");
    acc(4'h4, 3'h1, 8'hFF);
    @(posedge core_clk);
    extended_select <= 1'b0;
    acc(4'h8, 3'h1, 8'h00);
    chk(q, 8'h0F);
    acc(4'h4, 3'h1, 8'h00);
    ev(9'h020, 4'h1, 1'b0);
    acc(4'h8, 3'h5, 8'h00);
    chk(q, 8'h15);
    acc(4'h4, 3'h1, 8'h0F);
    @(posedge core_clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    sys_rst <= 1'b0;
    acc(4'h8, 3'h1, 8'h00);
    chk(q, 8'h00);
    $display("test clear and second reset done");
    tally_and_finish();
  end
endmodule
